// File: hw/pmu_alarm_ctrl.sv
// alarm latching, open-drain alarm drive, interface select and sense routing
// assumes fault inputs are asynchronous pins and config comes from serial logic on clock
`timescale 1ns/100ps
`default_nettype none
`include "pmu_ctrl_regs.svh"

// Operation
// - thermal alarm latched, active low, over trip
// - latched and live temperature flags
// - latched temperature cleared by bit six write
// - guard clamp alarm disabled after reset
// - control enables alarm, picks latched mode
// - guard and clamp reporting enabled separately
// - per channel latched and live flags
// - low reset returns every node to default
// - select pin low serial, high differential
// - undriven select pin defaults to serial
// - differential mode repurposes comparator output pins
// - shared low sense unless per channel selected
// - measure output mux voltage, current, temperature
// - guard input default; low sense routes high sense
module pmu_alarm_ctrl
	import pmu_ctrl_pkg::*;
(
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic [7:0]               temperature,
	input  wire logic                     trip_write,
	input  wire logic [7:0]               trip_data,
	input  wire logic                     unit_reg_write,
	input  wire logic [15:0]              unit_reg_data,
	input  wire alarm_cfg_t               alarm_cfg,
	input  wire logic [`NUM_CHANNELS-1:0] guard_fault,
	input  wire logic [`NUM_CHANNELS-1:0] clamp_fault,
	input  wire logic                     if_select_pin,
	input  wire logic [`NUM_CHANNELS-1:0] low_sense_sel,
	input  wire logic [2*`NUM_CHANNELS-1:0] meas_sel,
	output logic                          thermal_alarm_n_o,
	output logic                          thermal_alarm_n_oe,
	output logic                          guard_clamp_alarm_n_o,
	output logic                          guard_clamp_alarm_n_oe,
	output alarm_status_t                 status,
	output if_mode_t                      if_mode,
	output logic                          comparator_pins_diff,
	output logic [`NUM_CHANNELS-1:0]      low_sense_per_channel,
	output logic [`NUM_CHANNELS-1:0]      guard_from_high_sense,
	output logic [2*`NUM_CHANNELS-1:0]    measure_route
);
	// rst is the synchronised, inverted reset pin; asynchronous assertion keeps it level acting
	logic [2*`NUM_CHANNELS:0] sync1_reg, sync2_reg;
	logic [7:0]               trip_reg, trip_next;
	alarm_status_t            status_reg, status_next;
	logic                     gc_out_reg, gc_out_next;
	logic                     sel_reg, sel_next;
	logic                     sel_seen_reg, sel_seen_next, sel_take;
	logic [1:0]               strap_cnt_reg, strap_cnt_next;
	logic [2*`NUM_CHANNELS-1:0] route_reg, route_next;
	logic [`NUM_CHANNELS-1:0] lsense_reg, lsense_next;
	logic                     temp_over, clear_hit, gc_live, gc_latched;
	logic [`NUM_CHANNELS-1:0] g_now, c_now;

	function automatic logic any_alarm(input logic [`NUM_CHANNELS-1:0] g,
		input logic [`NUM_CHANNELS-1:0] c, input alarm_cfg_t cfg);
		any_alarm = (cfg.guard_en & |g) | (cfg.clamp_en & |c);
	endfunction

	// set wins over clear, so a cause still present in the clearing cycle is never lost
	function automatic logic [`NUM_CHANNELS-1:0] latch_flags(
		input logic [`NUM_CHANNELS-1:0] cause,
		input logic [`NUM_CHANNELS-1:0] flags,
		input logic                     clear);
		latch_flags = cause | (flags & {`NUM_CHANNELS{~clear}});
	endfunction

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {if_select_pin, clamp_fault, guard_fault};
			sync2_reg <= sync1_reg;
		end
	end

	always_comb begin
		g_now     = sync2_reg[`NUM_CHANNELS-1:0];
		c_now     = sync2_reg[2*`NUM_CHANNELS-1:`NUM_CHANNELS];
		temp_over = temperature > trip_reg;
		clear_hit = unit_reg_write & unit_reg_data[`CLEAR_BIT_POS];
		trip_next = trip_write ? trip_data : trip_reg;
		status_next = status_reg;
		status_next.temp_live   = temp_over;
		status_next.guard_live  = g_now;
		status_next.clamp_live  = c_now;
		// an over-temperature in the clearing cycle keeps the flag set
		status_next.temp_latched = temp_over | (status_reg.temp_latched & ~clear_hit);
		status_next.guard_latched = latch_flags(g_now, status_reg.guard_latched, clear_hit);
		status_next.clamp_latched = latch_flags(c_now, status_reg.clamp_latched, clear_hit);
		gc_live    = any_alarm(g_now, c_now, alarm_cfg);
		gc_latched = any_alarm(status_next.guard_latched, status_next.clamp_latched, alarm_cfg);
		gc_out_next = alarm_cfg.enable & (alarm_cfg.latched_mode ? gc_latched : gc_live);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trip_reg   <= `TEMP_TRIP_DEFAULT;
			status_reg <= '0;
			gc_out_reg <= 1'b0;
		end else begin
			trip_reg   <= trip_next;
			status_reg <= status_next;
			gc_out_reg <= gc_out_next;
		end
	end

	// the strap is read once, at the first edge at which the synchroniser holds the pin;
	// later changes of the pin are ignored so a glitching strap cannot swap interfaces
	always_comb begin
		strap_cnt_next = sel_seen_reg ? strap_cnt_reg : strap_cnt_reg + 2'h1;
		sel_take       = ~sel_seen_reg & (strap_cnt_reg == `STRAP_SAMPLE_EDGE);
		sel_next       = sel_take ? sync2_reg[2*`NUM_CHANNELS] : sel_reg;
		sel_seen_next  = sel_seen_reg | sel_take;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strap_cnt_reg <= 2'h0;
			sel_reg       <= 1'b0;
			sel_seen_reg  <= 1'b0;
		end else begin
			strap_cnt_reg <= strap_cnt_next;
			sel_reg       <= sel_next;
			sel_seen_reg  <= sel_seen_next;
		end
	end

	// routing selections only pass a register; the analog switches follow these bits
	always_comb begin
		route_next  = meas_sel;
		lsense_next = low_sense_sel;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			route_reg  <= '0;
			lsense_reg <= '0;
		end else begin
			route_reg  <= route_next;
			lsense_reg <= lsense_next;
		end
	end

	always_comb begin
		thermal_alarm_n_o      = 1'b0;
		thermal_alarm_n_oe     = status_reg.temp_latched;
		guard_clamp_alarm_n_o  = 1'b0;
		guard_clamp_alarm_n_oe = gc_out_reg;
		status                 = status_reg;
		if_mode                = sel_reg ? IF_DIFF : IF_SERIAL;
		comparator_pins_diff   = sel_reg;
		low_sense_per_channel  = lsense_reg;
		guard_from_high_sense  = lsense_reg;
		measure_route          = route_reg;
	end

	// every check samples on the one clock and is quiet while reset is applied
	a_temp_latch: assert property (@(posedge clock) disable iff (rst)
		status_reg.temp_live |-> thermal_alarm_n_oe)
		else $error("temp alarm not latched");
	a_temp_hold: assert property (@(posedge clock) disable iff (rst)
		thermal_alarm_n_oe && !clear_hit |=> thermal_alarm_n_oe)
		else $error("temp alarm dropped");
	a_temp_clear: assert property (@(posedge clock) disable iff (rst)
		clear_hit && !temp_over |=> !thermal_alarm_n_oe)
		else $error("temp alarm not cleared");
	a_temp_live: assert property (@(posedge clock) disable iff (rst)
		temp_over |=> status_reg.temp_live && status_reg.temp_latched)
		else $error("temp flags not set");
	a_temp_cool: assert property (@(posedge clock) disable iff (rst)
		!temp_over |=> !status_reg.temp_live)
		else $error("live temp flag stuck");
	a_gc_disabled: assert property (@(posedge clock) disable iff (rst)
		!alarm_cfg.enable |=> !guard_clamp_alarm_n_oe)
		else $error("disabled alarm drives");
	a_gc_live: assert property (@(posedge clock) disable iff (rst)
		alarm_cfg.enable && !alarm_cfg.latched_mode && gc_live |=> guard_clamp_alarm_n_oe)
		else $error("live alarm missing");
	a_gc_latched: assert property (@(posedge clock) disable iff (rst)
		alarm_cfg.enable && alarm_cfg.latched_mode && alarm_cfg.guard_en && !clear_hit &&
		(status_reg.guard_latched != '0) |=> guard_clamp_alarm_n_oe)
		else $error("latched alarm missing");
	a_gc_mask: assert property (@(posedge clock) disable iff (rst)
		!alarm_cfg.guard_en && !alarm_cfg.clamp_en |=> !guard_clamp_alarm_n_oe)
		else $error("masked alarm drives");
	a_flag_live: assert property (@(posedge clock) disable iff (rst)
		$rose(sync2_reg[0]) |=> status_reg.guard_live[0] && status_reg.guard_latched[0])
		else $error("guard flag missing");
	a_clamp_flag: assert property (@(posedge clock) disable iff (rst)
		$rose(c_now[0]) |=> status_reg.clamp_live[0] && status_reg.clamp_latched[0])
		else $error("clamp flag missing");
	a_gc_clear: assert property (@(posedge clock) disable iff (rst)
		clear_hit && (g_now == '0) && (c_now == '0) |=>
		(status_reg.guard_latched == '0) && (status_reg.clamp_latched == '0))
		else $error("fault flags not cleared");
	a_sel_fixed: assert property (@(posedge clock) disable iff (rst)
		sel_seen_reg |=> $stable(sel_reg))
		else $error("select changed after strap");
	a_strap_take: assert property (@(posedge clock) disable iff (rst)
		sel_take |=> sel_reg == $past(sync2_reg[2*`NUM_CHANNELS]))
		else $error("strap not taken");
	a_serial_default: assert property (@(posedge clock) disable iff (rst)
		!sel_reg |-> if_mode == IF_SERIAL)
		else $error("serial mode missing");
	a_diff_pins: assert property (@(posedge clock) disable iff (rst)
		comparator_pins_diff == (if_mode == IF_DIFF))
		else $error("pin role mismatch");
	a_low_sense: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> low_sense_per_channel == $past(low_sense_sel) && guard_from_high_sense == $past(low_sense_sel))
		else $error("low sense routing wrong");
	a_meas_route: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> measure_route == $past(meas_sel))
		else $error("measure routing wrong");
	a_od_level: assert property (@(posedge clock) disable iff (rst)
		!thermal_alarm_n_o && !guard_clamp_alarm_n_o)
		else $error("open drain drives high");

	c_temp_trip: cover property (@(posedge clock) disable iff (rst) $rose(thermal_alarm_n_oe));
	c_temp_clear: cover property (@(posedge clock) disable iff (rst) $fell(thermal_alarm_n_oe));
	c_gc_latched: cover property (@(posedge clock) disable iff (rst)
		alarm_cfg.latched_mode && !gc_live && guard_clamp_alarm_n_oe);
	c_diff_mode: cover property (@(posedge clock) disable iff (rst) sel_seen_reg && sel_reg);
	c_clamp_alarm: cover property (@(posedge clock) disable iff (rst)
		alarm_cfg.clamp_en && (status_reg.clamp_latched != '0) && guard_clamp_alarm_n_oe);
endmodule // pmu_alarm_ctrl
`default_nettype wire

// File: hw/pmu_ctrl_regs.svh
// constants for the measurement unit alarm, reset and interface select logic
// assumes inclusion by the package and the design module only
`ifndef PMU_CTRL_REGS_SVH
`define PMU_CTRL_REGS_SVH
`define NUM_CHANNELS      4
`define TEMP_TRIP_DEFAULT 8'h82
`define CLEAR_BIT_POS     6
// edge count after release at which the strap is read: two synchroniser edges must pass first
`define STRAP_SAMPLE_EDGE 2'h2
`define MEAS_SEL_VOLTAGE  2'h0
`define MEAS_SEL_CURRENT  2'h1
`define MEAS_SEL_TEMP     2'h2
`endif

// File: hw/pmu_ctrl_pkg.sv
// types shared by the measurement unit control logic
// assumes the constants header sits beside it
`include "pmu_ctrl_regs.svh"
package pmu_ctrl_pkg;
	typedef struct packed {
		logic enable;
		logic latched_mode;
		logic guard_en;
		logic clamp_en;
	} alarm_cfg_t;
	typedef struct packed {
		logic [`NUM_CHANNELS-1:0] guard_latched;
		logic [`NUM_CHANNELS-1:0] guard_live;
		logic [`NUM_CHANNELS-1:0] clamp_latched;
		logic [`NUM_CHANNELS-1:0] clamp_live;
		logic                     temp_latched;
		logic                     temp_live;
	} alarm_status_t;
	typedef enum logic [1:0] {
		IF_SERIAL = 2'b01,
		IF_DIFF   = 2'b10
	} if_mode_t;
endpackage

// File: verification/host_model.sv
// host side of the alarm lines and the interface strap
// assumes oe high means the device pulls its open-drain pin low
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input  wire logic t_oe,
	input  wire logic t_o,
	input  wire logic g_oe,
	input  wire logic g_o,
	input  wire logic strap_drive,
	input  wire logic strap_val,
	output wire logic t_pin,
	output wire logic g_pin,
	output wire logic sel_pin
);
	// board pull-ups take the released open-drain lines high
	assign t_pin   = t_oe ? t_o : 1'b1;
	assign g_pin   = g_oe ? g_o : 1'b1;
	// pull-down when nobody drives the strap
	assign sel_pin = strap_drive ? strap_val : 1'b0;
endmodule // host_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the alarm, reset and interface select logic
// assumes the package and host_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pmu_ctrl_pkg::*;
	logic clock = 0, rst = 1, trip_write = 0, unit_reg_write = 0, strap_drive = 0, strap_val = 0;
	logic [7:0] temperature = 8'h00, trip_data = 8'h00, meas_sel = 8'h00, mroute;
	logic [15:0] unit_reg_data = 16'h0000;
	alarm_cfg_t alarm_cfg = '0;
	logic [3:0] guard_fault = 4'h0, clamp_fault = 4'h0, low_sense_sel = 4'h0, lsp, gfh;
	wire logic sel_pin, t_o, t_oe, g_o, g_oe, cmp_diff, t_pin, g_pin;
	alarm_status_t status;
	if_mode_t if_mode;
	integer failures = 0, n_checks = 0, seed = 96, trip = 130, i, tl = 0, gl = 0, cl = 0;
	always #5 clock = ~clock;
	pmu_alarm_ctrl uut (.clock(clock), .rst(rst), .temperature(temperature),
		.trip_write(trip_write), .trip_data(trip_data), .unit_reg_write(unit_reg_write),
		.unit_reg_data(unit_reg_data), .alarm_cfg(alarm_cfg), .guard_fault(guard_fault),
		.clamp_fault(clamp_fault), .if_select_pin(sel_pin), .low_sense_sel(low_sense_sel),
		.meas_sel(meas_sel), .thermal_alarm_n_o(t_o), .thermal_alarm_n_oe(t_oe),
		.guard_clamp_alarm_n_o(g_o), .guard_clamp_alarm_n_oe(g_oe), .status(status),
		.if_mode(if_mode), .comparator_pins_diff(cmp_diff), .low_sense_per_channel(lsp),
		.guard_from_high_sense(gfh), .measure_route(mroute));
	host_model host (.t_oe(t_oe), .t_o(t_o), .g_oe(g_oe), .g_o(g_o), .strap_drive(strap_drive),
		.strap_val(strap_val), .t_pin(t_pin), .g_pin(g_pin), .sel_pin(sel_pin));
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input integer n);
		repeat (n) @(negedge clock);
	endtask
	task automatic do_reset(input logic s);
		strap_drive = s;
		strap_val = s;
		rst = 1;
		cyc(8);
		rst = 0;
		tl = 0;
		gl = 0;
		cl = 0;
		trip = 130;
		cyc(3);
	endtask
	// waits past the two-flop fault sync, then compares pins and flags with the model
	task automatic step;
		logic [3:0] gs, cs;
		logic gp;
		cyc(5);
		tl = tl | (temperature > trip);
		gl = gl | guard_fault;
		cl = cl | clamp_fault;
		gs = alarm_cfg.latched_mode ? gl[3:0] : guard_fault;
		cs = alarm_cfg.latched_mode ? cl[3:0] : clamp_fault;
		gp = alarm_cfg.enable & |(gs & {4{alarm_cfg.guard_en}} | cs & {4{alarm_cfg.clamp_en}});
		chk({t_pin, g_pin, status}, {~tl[0], ~gp, gl[3:0], guard_fault, cl[3:0], clamp_fault,
			tl[0], temperature > trip});
	endtask
	task automatic clr(input logic b6);
		unit_reg_data = 16'($random(seed));
		unit_reg_data[6] = b6;
		unit_reg_write = 1;
		cyc(1);
		unit_reg_write = 0;
		if (b6) begin
			tl = 0;
			gl = 0;
			cl = 0;
		end
	endtask
	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		do_reset(0);
		step;
		chk({if_mode, cmp_diff}, {IF_SERIAL, 1'b0});
		temperature = 8'h83;
		step;
		temperature = 8'h82;
		step;
		clr(0);
		step;
		clr(1);
		step;
		trip_data = 8'h64;
		trip_write = 1;
		cyc(1);
		trip_write = 0;
		trip = 100;
		temperature = 8'h65;
		step;
		clr(1);
		step;
		temperature = 8'h00;
		clr(1);
		step;
		$display("thermal test done");
		for (i = 0; i < 16; i++) begin
			alarm_cfg = 4'(i);
			guard_fault = 4'($random(seed));
			clamp_fault = 4'($random(seed));
			step;
			guard_fault = 4'h0;
			clamp_fault = 4'h0;
			step;
			clr(1);
			step;
		end
		$display("guard clamp test done");
		low_sense_sel = 4'($random(seed));
		meas_sel = 8'($random(seed));
		cyc(2);
		chk({lsp, gfh, mroute}, {low_sense_sel, low_sense_sel, meas_sel});
		guard_fault = 4'hF;
		cyc(5);
		guard_fault = 4'h0;
		do_reset(1);
		step;
		chk({if_mode, cmp_diff}, {IF_DIFF, 1'b1});
		$display("reset and strap test done");
		results;
	end
endmodule // testbench
`default_nettype wire
